// ### spcc_map.vh
// spcc_map.vh: register offsets, field positions and reset values
// assumes: included by spcc_top.v by bare name, no other definitions
//
// Contract
// - direction clear: data pin both ways, output pin off
// - direction set: reads on output pin only
// - order clear: msb first, address decrements
// - order set: lsb first, address increments
// - soft reset restores defaults, then self-clears
// - readback select picks staging or active copies
// - polarity bit inverts correction direction
// - three-bit current code, eight equal steps
// - antibacklash code picks pulse width
`ifndef SPCC_MAP_VH
`define SPCC_MAP_VH

// register offsets (13-bit serial address space)
`define SPCC_ADDR_CFG      13'h0000
`define SPCC_ADDR_RBSEL    13'h0004
`define SPCC_ADDR_PUMP     13'h0010
`define SPCC_ADDR_UPDATE   13'h0232

// serial port config fields
`define SPCC_CFG_DIR       7
`define SPCC_CFG_LSB       6
`define SPCC_CFG_SRST      5
`define SPCC_RBSEL_BIT     0
`define SPCC_UPDATE_BIT    0

// pump / detector config fields
`define SPCC_PUMP_POL      7
`define SPCC_PUMP_CUR_HI   6
`define SPCC_PUMP_CUR_LO   4
`define SPCC_PUMP_MODE_HI  3
`define SPCC_PUMP_MODE_LO  2
`define SPCC_PUMP_ABL_HI   1
`define SPCC_PUMP_ABL_LO   0

// reset values
`define SPCC_RST_CFG       8'h00
`define SPCC_RST_RBSEL     8'h00
`define SPCC_RST_PUMP      8'h7c

// serial frame sizes and counts
`define SPCC_INSTR_LAST    4'hf
`define SPCC_BYTE_LAST     4'h7

`endif

// ### spcc_top.v
// spcc_top.v: serial port and pump/detector config register slice
// assumes: host drives sclk, cs_n, sdio as async pins; the wire level
// of the two-way pins is resolved outside from the enables
`timescale 1ns/10ps
`default_nettype none
`include "spcc_map.vh"

module spcc_top (
  input  wire       clk,
  input  wire       rst,
  input  wire       sclk,
  input  wire       cs_n,
  input  wire       sdio_i,
  output wire       sdio_o,
  output wire       sdio_oe,
  output wire       serial_output_pin_o,
  output wire       serial_output_pin_oe,
  output wire       cp_invert,
  output wire [2:0] cp_current,
  output wire [3:0] cp_step,
  output wire       cp_hiz,
  output wire       cp_force_up,
  output wire       cp_force_dn,
  output wire [1:0] abl_sel
);

  //////////////////////////////////////////////////////////////////
  // pin synchronisers
  //////////////////////////////////////////////////////////////////

  // idle level of {sdio, cs_n, sclk}: select released high and the
  // serial clock parked high, so no false clock edge follows reset
  localparam [2:0] LVL_RST = 3'h3;

  wire [2:0] pin_raw;      // raw pins
  reg  [2:0] sync1_q;      // first stage, read by second only
  reg  [2:0] sync2_q;      // second stage
  reg  [2:0] sync3_q;      // third stage
  reg  [2:0] lvl_q;        // accepted level
  wire [2:0] lvl_d;        // next accepted level

  assign pin_raw = {sdio_i, cs_n, sclk};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      // level changes only once stages two and three agree
      assign lvl_d[gi] = (sync2_q[gi] == sync3_q[gi]) ?
                         sync2_q[gi] : lvl_q[gi];
      // three-stage chain per pin
      always @(posedge clk) begin
        if (rst) begin
          sync1_q[gi] <= LVL_RST[gi];
          sync2_q[gi] <= LVL_RST[gi];
          sync3_q[gi] <= LVL_RST[gi];
          lvl_q[gi]   <= LVL_RST[gi];
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          lvl_q[gi]   <= lvl_d[gi];
        end
      end
    end
  endgenerate

  wire sclk_rise;          // serial clock rising edge event
  wire sclk_fall;          // serial clock falling edge event
  wire sel_act;            // chip select asserted
  wire din;                // accepted data bit

  assign sclk_rise = lvl_d[0] & ~lvl_q[0];
  assign sclk_fall = ~lvl_d[0] & lvl_q[0];
  assign sel_act   = ~lvl_d[1];
  assign din       = lvl_d[2];

  //////////////////////////////////////////////////////////////////
  // register state
  //////////////////////////////////////////////////////////////////

  // reset images of the immediate registers, picked apart per field
  localparam [7:0] RST_CFG   = `SPCC_RST_CFG;
  localparam [7:0] RST_RBSEL = `SPCC_RST_RBSEL;

  reg        dir_q;        // port direction: 1 = separate output pin
  reg        lsb_q;        // bit order: 1 = lsb first, addr up
  reg        srst_q;       // soft reset pending, self-clearing
  reg        rbsel_q;      // readback source: 1 = active copies
  reg  [7:0] pump_buf_q;   // staging copy of pump config
  reg  [7:0] pump_act_q;   // active copy of pump config

  //////////////////////////////////////////////////////////////////
  // serial frame state
  //////////////////////////////////////////////////////////////////

  localparam PH_INSTR = 1'b0; // collecting 16-bit instruction
  localparam PH_DATA  = 1'b1; // moving data bytes

  reg        phase_q;      // frame phase
  reg  [3:0] cnt_q;        // bit count in current unit
  reg [15:0] ish_q;        // instruction shifter
  reg  [7:0] dsh_q;        // write data shifter
  reg  [7:0] osh_q;        // read data shifter
  reg        rd_q;         // current frame is a read
  reg [12:0] addr_q;       // current register address
  reg        obit_q;       // read bit being presented

  wire [15:0] ish_nx;      // instruction after this bit
  wire  [7:0] dsh_nx;      // data byte after this bit
  wire [12:0] addr_step;   // address of next byte
  wire        instr_done;  // last instruction bit taken
  wire        byte_done;   // last data bit taken
  wire        wr_en;       // write of a whole byte
  wire [12:0] rd_addr;     // address whose byte loads next
  reg   [7:0] rd_byte;     // readback mux output

  // shift direction follows bit order
  assign ish_nx = lsb_q ? {din, ish_q[15:1]} : {ish_q[14:0], din};
  assign dsh_nx = lsb_q ? {din, dsh_q[7:1]} : {dsh_q[6:0], din};

  // address steps down msb first, up lsb first
  assign addr_step = lsb_q ? (addr_q + 13'h0001) :
                             (addr_q - 13'h0001);

  assign instr_done = sel_act & sclk_rise & (phase_q == PH_INSTR) &
                      (cnt_q == `SPCC_INSTR_LAST);
  assign byte_done  = sel_act & sclk_rise & (phase_q == PH_DATA) &
                      (cnt_q == `SPCC_BYTE_LAST);
  assign wr_en      = byte_done & ~rd_q;
  assign rd_addr    = instr_done ? ish_nx[12:0] : addr_step;

  //////////////////////////////////////////////////////////////////
  // readback mux
  //////////////////////////////////////////////////////////////////

  // config reads show the stored high bits mirrored into the low nibble
  always @* begin
    rd_byte = 8'h00;
    if (rd_addr == `SPCC_ADDR_CFG) begin
      rd_byte = {dir_q, lsb_q, srst_q, 1'b0,
                 1'b0, srst_q, lsb_q, dir_q};
    end else if (rd_addr == `SPCC_ADDR_RBSEL) begin
      rd_byte = {7'h00, rbsel_q};
    end else if (rd_addr == `SPCC_ADDR_PUMP) begin
      // source picked by readback select
      rd_byte = rbsel_q ? pump_act_q : pump_buf_q;
    end else begin
      rd_byte = 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////
  // frame sequencer
  //////////////////////////////////////////////////////////////////

  // counts bits, latches the instruction, steps the address
  always @(posedge clk) begin
    if (rst || !sel_act) begin
      phase_q <= PH_INSTR;
      cnt_q   <= 4'h0;
      ish_q   <= 16'h0000;
      dsh_q   <= 8'h00;
      rd_q    <= 1'b0;
      addr_q  <= 13'h0000;
    end else if (sclk_rise) begin
      cnt_q <= cnt_q + 4'h1;
      case (phase_q)
        PH_INSTR: begin
          ish_q <= ish_nx;
          if (instr_done) begin
            // bit 15 marks a read, low 13 bits the address
            phase_q <= PH_DATA;
            cnt_q   <= 4'h0;
            rd_q    <= ish_nx[15];
            addr_q  <= ish_nx[12:0];
          end
        end
        default: begin
          dsh_q <= dsh_nx;
          if (byte_done) begin
            // multibyte: next byte at stepped address
            cnt_q  <= 4'h0;
            addr_q <= addr_step;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////
  // read data shifter
  //////////////////////////////////////////////////////////////////

  // load on the rising edge, present bits on falling edges
  always @(posedge clk) begin
    if (rst) begin
      osh_q  <= 8'h00;
      obit_q <= 1'b0;
    end else if (instr_done || byte_done) begin
      osh_q <= rd_byte;
    end else if (sel_act && sclk_fall && phase_q == PH_DATA) begin
      // first bit out depends on order
      obit_q <= lsb_q ? osh_q[0] : osh_q[7];
      osh_q  <= lsb_q ? {1'b0, osh_q[7:1]} : {osh_q[6:0], 1'b0};
    end
  end

  //////////////////////////////////////////////////////////////////
  // register file
  //////////////////////////////////////////////////////////////////

  // writes, soft reset and the update command
  always @(posedge clk) begin
    if (rst || srst_q) begin
      // soft reset restores every default, clearing itself
      dir_q      <= RST_CFG[`SPCC_CFG_DIR];
      lsb_q      <= RST_CFG[`SPCC_CFG_LSB];
      srst_q     <= 1'b0;
      rbsel_q    <= RST_RBSEL[`SPCC_RBSEL_BIT];
      pump_buf_q <= `SPCC_RST_PUMP;
      pump_act_q <= `SPCC_RST_PUMP;
    end else if (wr_en) begin
      if (addr_q == `SPCC_ADDR_CFG) begin
        // only the high bits steer; low nibble is the mirror
        dir_q  <= dsh_nx[`SPCC_CFG_DIR];
        lsb_q  <= dsh_nx[`SPCC_CFG_LSB];
        srst_q <= dsh_nx[`SPCC_CFG_SRST];
      end else if (addr_q == `SPCC_ADDR_RBSEL) begin
        rbsel_q <= dsh_nx[`SPCC_RBSEL_BIT];
      end else if (addr_q == `SPCC_ADDR_PUMP) begin
        pump_buf_q <= dsh_nx;                // staging only
      end else if (addr_q == `SPCC_ADDR_UPDATE) begin
        if (dsh_nx[`SPCC_UPDATE_BIT]) begin
          pump_act_q <= pump_buf_q;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // pin drivers
  //////////////////////////////////////////////////////////////////

  reg sdio_o_q;            // data pin output
  reg sdio_oe_q;           // data pin enable
  reg sdo_o_q;             // separate output pin
  reg sdo_oe_q;            // separate output pin enable
  wire rd_phase;           // read data being returned

  assign rd_phase = sel_act & (phase_q == PH_DATA) & rd_q;

  // route read data by the direction bit
  always @(posedge clk) begin
    if (rst) begin
      sdio_o_q  <= 1'b0;
      sdio_oe_q <= 1'b0;
      sdo_o_q   <= 1'b0;
      sdo_oe_q  <= 1'b0;
    end else begin
      sdio_o_q  <= obit_q;
      sdo_o_q   <= obit_q;
      // bidirectional: data pin drives, output pin stays off
      sdio_oe_q <= rd_phase & ~dir_q;
      // unidirectional: only the output pin drives
      sdo_oe_q  <= rd_phase & dir_q;
    end
  end

  //////////////////////////////////////////////////////////////////
  // pump / detector decode
  //////////////////////////////////////////////////////////////////

  reg       inv_q;         // detector polarity inverted
  reg [2:0] cur_q;         // current code
  reg [3:0] step_q;        // current in 0.6 mA units, 1..8
  reg       hiz_q;         // pump off
  reg       up_q;          // forced source
  reg       dn_q;          // forced sink
  reg [1:0] abl_q;         // 0 short, 1 medium, 2 long

  wire [2:0] cur_code;     // active current field
  wire [1:0] mode_code;    // active mode field
  wire [1:0] abl_code;     // active antibacklash field

  assign cur_code  = pump_act_q[`SPCC_PUMP_CUR_HI:`SPCC_PUMP_CUR_LO];
  assign mode_code = pump_act_q[`SPCC_PUMP_MODE_HI:`SPCC_PUMP_MODE_LO];
  assign abl_code  = pump_act_q[`SPCC_PUMP_ABL_HI:`SPCC_PUMP_ABL_LO];

  // decodes follow the active copy only
  always @(posedge clk) begin
    if (rst) begin
      inv_q  <= 1'b0;
      cur_q  <= 3'h7;
      step_q <= 4'h8;
      hiz_q  <= 1'b0;
      up_q   <= 1'b0;
      dn_q   <= 1'b0;
      abl_q  <= 2'h1;
    end else begin
      inv_q  <= pump_act_q[`SPCC_PUMP_POL];
      cur_q  <= cur_code;
      step_q <= {1'b0, cur_code} + 4'h1;
      hiz_q  <= (mode_code == 2'h0);
      up_q   <= (mode_code == 2'h1);
      dn_q   <= (mode_code == 2'h2);
      // 00 and 11 medium, 01 short, 10 long
      case (abl_code)
        2'h1:    abl_q <= 2'h0;
        2'h2:    abl_q <= 2'h2;
        default: abl_q <= 2'h1;
      endcase
    end
  end

  assign sdio_o               = sdio_o_q;
  assign sdio_oe              = sdio_oe_q;
  assign serial_output_pin_o  = sdo_o_q;
  assign serial_output_pin_oe = sdo_oe_q;
  assign cp_invert            = inv_q;
  assign cp_current           = cur_q;
  assign cp_step              = step_q;
  assign cp_hiz               = hiz_q;
  assign cp_force_up          = up_q;
  assign cp_force_dn          = dn_q;
  assign abl_sel              = abl_q;

endmodule

`default_nettype wire

// ### spcc_props.sv
// spcc_props.sv: port assertions for the config slice
// assumes: bound to spcc_top, one clock domain
`timescale 1ns/10ps
`default_nettype none
module spcc_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       cs_n,
  input wire logic       sdio_oe,
  input wire logic       serial_output_pin_oe,
  input wire logic       cp_invert,
  input wire logic [2:0] cp_current,
  input wire logic [3:0] cp_step,
  input wire logic       cp_hiz,
  input wire logic       cp_force_up,
  input wire logic       cp_force_dn,
  input wire logic [1:0] abl_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // host has left the port deselected for eight clocks
  sequence s_idle;
    cs_n [*8];
  endsequence
  // first clock after reset is released
  sequence s_released;
    $fell(rst);
  endsequence
  a_step_code: assert property (
    cp_step == {1'b0, cp_current} + 4'h1) else $error("step not code+1");
  a_mode_exclusive: assert property (
    $onehot0({cp_hiz, cp_force_up, cp_force_dn})) else $error("two modes");
  a_abl_legal: assert property (
    abl_sel != 2'h3) else $error("bad pulse width select");
  a_reset_pump: assert property (
    s_released |-> cp_current == 3'h7 && !cp_invert && abl_sel == 2'h1 &&
    !(cp_hiz | cp_force_up | cp_force_dn)) else $error("pump not default");
  a_reset_pins: assert property (
    s_released |-> !sdio_oe && !serial_output_pin_oe)
    else $error("pin driven after reset");
  a_one_driver: assert property (
    !(sdio_oe && serial_output_pin_oe)) else $error("both pins driven");
  a_idle_quiet: assert property (
    s_idle |-> !sdio_oe && !serial_output_pin_oe)
    else $error("pin driven while idle");
  a_idle_hold: assert property (
    s_idle |=> $stable({cp_invert, cp_current, cp_hiz, cp_force_up,
    cp_force_dn, abl_sel})) else $error("active changed while idle");
endmodule
bind spcc_top spcc_props u_props (.clk(clk), .rst(rst), .cs_n(cs_n),
  .sdio_oe(sdio_oe), .serial_output_pin_oe(serial_output_pin_oe),
  .cp_invert(cp_invert), .cp_current(cp_current), .cp_step(cp_step),
  .cp_hiz(cp_hiz), .cp_force_up(cp_force_up),
  .cp_force_dn(cp_force_dn), .abl_sel(abl_sel));
`default_nettype wire

// ### spcc_host.sv
// spcc_host.sv: serial host model for the config port
// assumes: sclk phases of 12/8 clk; data pin has no pull
`timescale 1ns/10ps
`default_nettype none
module spcc_host (
  input  wire logic clk,
  input  wire logic sdio_o,
  input  wire logic sdio_oe,
  input  wire logic so_o,
  input  wire logic so_oe,
  output var  logic sclk,
  output var  logic cs_n,
  output wire logic sdio_i
);
  logic drv, dbit, last; // host drive, its bit, last wire level
  // undriven wire wanders so stale data never matches
  assign sdio_i = drv ? dbit : sdio_oe ? sdio_o : ~last;
  always @(posedge clk) last <= sdio_i;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    drv = 1'b0;
    dbit = 1'b0;
    last = 1'b0;
  end
  // one frame: instruction, then bytes, cut after nbits
  task automatic xfer(input logic rd, lsb, uni, input logic [12:0] a,
                      input int nbits, input logic [15:0] wd,
                      output logic [15:0] q);
    logic [31:0] s, r; // bits sent, bits seen
    int b, w, p;       // field base, field width, bit position
    s = {wd, rd, 2'b00, a};
    r = '0;
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int n = 0; n < nbits; n++) begin
      b = (n < 16) ? 0 : 16 + 8 * ((n - 16) / 8);
      w = (n < 16) ? 16 : 8;
      p = lsb ? n : b + w - 1 - (n - b);
      sclk <= 1'b0;
      dbit <= s[p];
      drv <= !(rd && n >= 16);
      repeat (12) @(posedge clk);
      r[p] = uni ? (so_oe ? so_o : ~last) : sdio_i;
      sclk <= 1'b1;
      repeat (8) @(posedge clk);
    end
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    drv <= 1'b0;
    repeat (12) @(posedge clk);
    q = r[31:16];
  endtask
endmodule
`default_nettype wire

// ### serial_port_and_pump_config_tb_top.sv
// serial_port_and_pump_config_tb_top.sv: self-checking bench
// assumes: spcc_host drives the port, spcc_props is bound
`timescale 1ns/10ps
`default_nettype none
module serial_port_and_pump_config_tb_top;
  logic        clk, rst, lsb, uni; // clock, reset, port mode
  wire         sclk, cs_n, sdio_i, sdio_o, sdio_oe, so_o, so_oe;
  wire         inv, hiz, up, dn;
  wire   [2:0] cur;
  wire   [3:0] stp;
  wire   [1:0] abl;
  wire  [12:0] obs = {inv, cur, stp, hiz, up, dn, abl};
  int          n_errors, n_tests;
  logic [15:0] q;      // read data
  logic  [7:0] v, act; // staged and active pump value
  spcc_top u_dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
    .serial_output_pin_o(so_o), .serial_output_pin_oe(so_oe),
    .cp_invert(inv), .cp_current(cur), .cp_step(stp), .cp_hiz(hiz),
    .cp_force_up(up), .cp_force_dn(dn), .abl_sel(abl));
  spcc_host u_host (.clk(clk), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
    .so_o(so_o), .so_oe(so_oe), .sclk(sclk), .cs_n(cs_n),
    .sdio_i(sdio_i));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // decoded pump outputs expected for a register value
  function automatic logic [15:0] dec(input logic [7:0] p);
    logic [1:0] a;
    a = (p[1:0] == 2'h1) ? 2'h0 : (p[1:0] == 2'h2) ? 2'h2 : 2'h1;
    return {3'h0, p[7], p[6:4], {1'b0, p[6:4]} + 4'h1,
            p[3:2] == 2'h0, p[3:2] == 2'h1, p[3:2] == 2'h2, a};
  endfunction
  task automatic chk(input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // one access in the current port mode
  task automatic acc(input logic rd, input logic [12:0] a, input int nb,
                     input logic [15:0] wd);
    u_host.xfer(rd, lsb, uni, a, 16 + 8 * nb, wd, q);
  endtask
  task automatic print_verdict;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    print_verdict;
  end
  initial begin
    rst = 1'b1;
    lsb = 1'b0;
    uni = 1'b0;
    act = 8'h7c;
    n_errors = 0;
    n_tests = 0;
    v = 8'($urandom(32'h88e6));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(16'(obs), dec(8'h7c));
    acc(1'b1, 13'h010, 1, 16'h0);
    chk(q, 16'h7c);
    // every code of each field, random polarity
    for (int i = 0; i < 8; i++) begin
      v = {1'($urandom), 3'(i), 2'(i), 2'(i >> 1)};
      acc(1'b0, 13'h010, 1, {8'h0, v});
      chk(16'(obs), dec(act));
      acc(1'b1, 13'h010, 1, 16'h0);
      chk(q, {8'h0, v});
      acc(1'b0, 13'h004, 1, 16'h1);
      acc(1'b1, 13'h010, 1, 16'h0);
      chk(q, {8'h0, act});
      acc(1'b0, 13'h232, 1, 16'h1);
      act = v;
      chk(16'(obs), dec(v));
      acc(1'b0, 13'h004, 1, 16'h0);
    end
    v = 8'($urandom);
    acc(1'b0, 13'h011, 2, {v, 8'h5a});
    acc(1'b1, 13'h011, 2, 16'h0);
    chk(q, {v, 8'h00});
    acc(1'b0, 13'h000, 1, 16'h81);
    uni = 1'b1;
    acc(1'b1, 13'h010, 1, 16'h0);
    chk(q, {8'h0, v});
    acc(1'b0, 13'h000, 1, 16'h42);
    uni = 1'b0;
    lsb = 1'b1;
    v = 8'($urandom);
    acc(1'b0, 13'h00f, 2, {v, 8'ha5});
    acc(1'b1, 13'h00f, 2, 16'h0);
    chk(q, {v, 8'h00});
    acc(1'b0, 13'h010, 1, 16'h05);
    acc(1'b0, 13'h232, 1, 16'h1);
    acc(1'b0, 13'h004, 1, 16'h1);
    acc(1'b0, 13'h000, 1, 16'h24);
    lsb = 1'b0;
    chk(16'(obs), dec(8'h7c));
    acc(1'b1, 13'h000, 1, 16'h0);
    chk(q, 16'h0);
    acc(1'b1, 13'h010, 1, 16'h0);
    chk(q, 16'h7c);
    print_verdict;
  end
endmodule
`default_nettype wire
